/* tb_uart_flow_control_core.sv */
`include "uart_map.vh"

module tb_uart_flow_control_core;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BAUD = 8;
  logic                   sys_clk_in = 1'b0;
  logic                   arst_n_in = 1'b0;
  logic [`UF_ADDR_W-1:0]  addr_in = '0;
  logic [`UF_DATA_W-1:0]  wdata_in = '0;
  logic                   wr_in = 1'b0;
  logic                   rd_in = 1'b0;
  logic [`UF_PIN_NUM-1:0] pin_in;
  wire  [`UF_DATA_W-1:0]  rdata_out;
  wire  [`UF_PIN_NUM-1:0] pin_out;
  wire  [`UF_PIN_NUM-1:0] pin_oe_out;
  wire                    rx_line;
  wire                    cts_n;
  logic [31:0]            d;
  int                     n_fail = 0;
  int                     checked = 0;
  int                     cycles = 0;

  uart_flow_control_core u_dut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out));
  uart_peer #(.BAUD(BAUD)) u_peer (.clk_in(sys_clk_in), .line_in(pin_in[1]),
    .rts_n_in(pin_in[0]), .line_out(rx_line), .cts_n_out(cts_n));

  // undriven pins are pulled up; pin 2 carries clear-to-send, pin 3 receive data
  always_comb
  begin
    pin_in = (pin_oe_out & pin_out) | ~pin_oe_out;
    pin_in[2] = cts_n;
    pin_in[3] = rx_line;
  end

  initial
    forever #10 sys_clk_in = ~sys_clk_in;

  initial
  begin
    repeat (20) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
  end

  task automatic final_report();
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic wait_ev(input logic [11:0] a, input int n);
    d = '0;
    for (int i = 0; i < n && d[0] !== 1'b1; i++)
      rd(a);
  endtask

  // event must show up, then it is cleared before anything depending on it
  task automatic ev(input logic [11:0] a, input int n);
    wait_ev(a, n);
    chk(d, 1);
    wr(a, 0);
  endtask

  task automatic rx_take(input logic [7:0] b);
    ev(`UF_OFS_EV_RX, 60);
    rd(`UF_OFS_RXD);
    chk(d, 32'(b));
  endtask

  task automatic tx_take(input logic [9:0] fe);
    ev(`UF_OFS_EV_TX, 60);
    chk(32'(u_peer.got_q.pop_front()), 32'(fe));
  endtask

  initial
  begin
    repeat (23) @(posedge sys_clk_in);
    rd(`UF_OFS_PSEL);
    chk(d, 32'h80000000);
    rd(`UF_OFS_BAUD);
    chk(d, 32'h000001B2);
    rd(12'hFFC);
    chk(d, 32'h0);
    for (int i = 0; i < 4; i++)
      wr(`UF_OFS_PSEL + 12'(4 * i), i);
    wr(`UF_OFS_BAUD, BAUD);
    wr(`UF_OFS_ENABLE, 1);
    idle(2);
    chk(pin_oe_out, 32'h3);
    wr(`UF_OFS_TXD, 32'h5A);
    idle(200);
    chk(u_peer.got_q.size(), 0);
    wr(`UF_OFS_TX_GO, 1);
    tx_take(10'h25A);
    u_peer.send(8'h11, 1'b1, 1'b0);
    rd(`UF_OFS_EV_RX);
    chk(d, 0);
    wr(`UF_OFS_RX_GO, 1);
    u_peer.send(8'h3C, 1'b1, 1'b1);
    rx_take(8'h3C);
    wr(`UF_OFS_CONFIG, 2);
    u_peer.par_on = 1'b1;
    wr(`UF_OFS_TXD, 32'h07);
    tx_take(10'h307);
    u_peer.send(8'h07, 1'b1, 1'b0);
    rx_take(8'h07);
    rd(`UF_OFS_ERRSRC);
    chk(d, 0);
    u_peer.par_bad = 1'b1;
    u_peer.send(8'h07, 1'b1, 1'b0);
    u_peer.par_bad = 1'b0;
    rx_take(8'h07);
    ev(`UF_OFS_EV_ERR, 60);
    rd(`UF_OFS_ERRSRC);
    chk(d, 2);
    wr(`UF_OFS_ERRSRC, 2);
    wr(`UF_OFS_CONFIG, 1);
    u_peer.par_on = 1'b0;
    idle(4);
    chk(32'(pin_in[0]), 0);
    for (int i = 0; i < 8; i++)
      u_peer.send(8'hA0 + 8'(i), 1'b1, 1'b0);
    chk(32'(pin_in[0]), 1);
    for (int i = 0; i < 8; i++)
    begin
      wait_ev(`UF_OFS_EV_RX, 4);
      if (d[0] === 1'b1)
      begin
        wr(`UF_OFS_EV_RX, 0);
        rd(`UF_OFS_RXD);
        if (i < 7)
          chk(d, (i == 6) ? 32'hA7 : 32'hA0 + i);
        if (i == 2)
          chk(32'(pin_in[0]), 1);
      end
    end
    chk(d, 0);
    idle(8);
    chk(32'(pin_in[0]), 0);
    wr(`UF_OFS_TXD, 32'h96);
    idle(20);
    u_peer.set_cts(1'b1);
    tx_take(10'h296);
    wr(`UF_OFS_TXD, 32'h69);
    idle(200);
    chk(u_peer.got_q.size(), 0);
    u_peer.set_cts(1'b0);
    tx_take(10'h269);
    wr(`UF_OFS_TXD, 32'hC3);
    idle(30);
    wr(`UF_OFS_TX_END, 1);
    idle(1);
    chk(32'(pin_in[1]), 1);
    idle(100);
    u_peer.got_q.delete();
    wr(`UF_OFS_EV_TX, 0);
    wr(`UF_OFS_RX_END, 1);
    idle(4);
    chk(32'(pin_in[0]), 1);
    u_peer.send(8'h4B, 1'b1, 1'b0);
    rx_take(8'h4B);
    ev(`UF_OFS_EV_TO, 200);
    u_peer.send(8'h22, 1'b1, 1'b0);
    idle(4);
    rd(`UF_OFS_EV_RX);
    chk(d, 0);
    wr(`UF_OFS_TX_GO, 1);
    wr(`UF_OFS_RX_GO, 1);
    wr(`UF_OFS_TXD, 32'hE1);
    idle(20);
    wr(`UF_OFS_SUSPEND, 1);
    tx_take(10'h2E1);
    ev(`UF_OFS_EV_TO, 200);
    wr(`UF_OFS_TXD, 32'h1E);
    idle(200);
    chk(u_peer.got_q.size(), 0);
    wr(`UF_OFS_TX_GO, 1);
    tx_take(10'h21E);
    wr(`UF_OFS_RX_GO, 1);
    u_peer.send(8'h5C, 1'b1, 1'b1);
    rx_take(8'h5C);
    u_peer.send(8'h00, 1'b0, 1'b0);
    ev(`UF_OFS_EV_ERR, 60);
    rd(`UF_OFS_ERRSRC);
    chk(d, 1);
    wr(`UF_OFS_ERRSRC, 1);
    u_peer.brk(300);
    ev(`UF_OFS_EV_ERR, 60);
    rd(`UF_OFS_ERRSRC);
    chk(d, 5);
    wr(`UF_OFS_ERRSRC, 5);
    rd(`UF_OFS_ERRSRC);
    chk(d, 0);
    final_report();
  end
endmodule // tb_uart_flow_control_core

/* uart_flow_control_core.v */
`include "uart_map.vh"

// Summary of operation
// - one stop bit sent and expected
// - even parity as ninth bit when configured
// - disconnected signal touches no pin
// - transmit starts only after begin-transmit task
// - one byte per data write, then sent event
// - end-transmit task stops transmitter immediately
// - flow control pauses on inactive clear-to-send
// - receive starts only after begin-receive task
// - six-entry receive FIFO, overwrite when full
// - data read pops, next byte moves in
// - request-to-send off at four free entries
// - request-to-send back only when all read
// - end-receive drops request-to-send, keeps receiving
// - receive timeout event after stop period
// - suspend finishes byte, acts as end-receive
// - begin tasks resume each direction independently
// - missing stop bit raises framing error
// - long low line raises break after framing
// - no flow control means lines always active
// - parity is even, both directions
module uart_flow_control_core (
  input  wire                   sys_clk_in,
  input  wire                   arst_n_in,
  input  wire [`UF_ADDR_W-1:0]  addr_in,
  input  wire [`UF_DATA_W-1:0]  wdata_in,
  input  wire                   wr_in,
  input  wire                   rd_in,
  output reg  [`UF_DATA_W-1:0]  rdata_out,
  input  wire [`UF_PIN_NUM-1:0] pin_in,
  output reg  [`UF_PIN_NUM-1:0] pin_out,
  output reg  [`UF_PIN_NUM-1:0] pin_oe_out
);

  localparam TX_IDLE  = 3'h0;
  localparam TX_START = 3'h1;
  localparam TX_DATA  = 3'h2;
  localparam TX_PAR   = 3'h3;
  localparam TX_STOP  = 3'h4;
  localparam RX_IDLE  = 3'h0;
  localparam RX_START = 3'h1;
  localparam RX_DATA  = 3'h2;
  localparam RX_STOP  = 3'h3;
  localparam RX_BRK   = 3'h4;

  reg rst_meta_reg;
  reg rst_n_reg;

  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // register decode
  wire        trig      = wr_in && wdata_in[0];
  wire        t_rx_go   = trig && (addr_in == `UF_OFS_RX_GO);
  wire        t_rx_end  = trig && (addr_in == `UF_OFS_RX_END);
  wire        t_tx_go   = trig && (addr_in == `UF_OFS_TX_GO);
  wire        t_tx_end  = trig && (addr_in == `UF_OFS_TX_END);
  wire        t_susp    = trig && (addr_in == `UF_OFS_SUSPEND);
  wire        wr_txd    = wr_in && (addr_in == `UF_OFS_TXD);
  wire        rd_rxd    = rd_in && (addr_in == `UF_OFS_RXD);
  wire [11:0] psel_ofs  = addr_in - `UF_OFS_PSEL;
  wire        psel_hit  = (psel_ofs < `UF_PSEL_SPAN) && (psel_ofs[1:0] == 2'h0);

  reg         enable_reg;
  reg  [1:0]  cfg_reg;
  reg  [15:0] baud_reg;
  wire        hwfc = cfg_reg[`UF_CFG_HWFC];
  wire        par_en = cfg_reg[`UF_CFG_PAR];

  // pin selects, one per serial signal
  wire [5:0]  psel [0:`UF_PSEL_NUM-1];
  genvar g;
  generate
    for (g = 0; g < `UF_PSEL_NUM; g = g + 1)
    begin : g_psel
      reg [5:0] sel_reg;
      always @(posedge sys_clk_in or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
          sel_reg <= `UF_PSEL_RST;
        else if (wr_in && psel_hit && psel_ofs[3:2] == g)
          sel_reg <= {wdata_in[`UF_PSEL_DISC], wdata_in[4:0]};
      end
      assign psel[g] = sel_reg;
    end
  endgenerate

  // a signal is attached only while enabled and connected
  wire rts_att = enable_reg && !psel[`UF_PSEL_RTS][5];
  wire txd_att = enable_reg && !psel[`UF_PSEL_TXD][5];
  wire cts_att = enable_reg && !psel[`UF_PSEL_CTS][5];
  wire rxd_att = enable_reg && !psel[`UF_PSEL_RXD][5];
  wire rxd_line = rxd_att ? pin_in[psel[`UF_PSEL_RXD][4:0]] : 1'b1;
  wire cts_n    = cts_att ? pin_in[psel[`UF_PSEL_CTS][4:0]] : 1'b1;
  wire cts_ok   = !hwfc || !cts_n;

  reg tx_line_reg;
  reg rts_off_reg;
  wire rts_n = hwfc ? rts_off_reg : 1'b0;

  always @*
  begin
    pin_out    = {`UF_PIN_NUM{1'b1}};
    pin_oe_out = {`UF_PIN_NUM{1'b0}};
    if (txd_att)
    begin
      pin_out[psel[`UF_PSEL_TXD][4:0]]    = tx_line_reg;
      pin_oe_out[psel[`UF_PSEL_TXD][4:0]] = 1'b1;
    end
    if (rts_att)
    begin
      pin_out[psel[`UF_PSEL_RTS][4:0]]    = rts_n;
      pin_oe_out[psel[`UF_PSEL_RTS][4:0]] = 1'b1;
    end
  end

  // transmitter
  reg [2:0]  tx_st_reg;
  reg [15:0] tx_cnt_reg;
  reg [3:0]  tx_bit_reg;
  reg [7:0]  tx_sh_reg;
  reg [7:0]  txd_reg;
  reg        tx_par_reg;
  reg        tx_on_reg;
  reg        tx_susp_reg;
  reg        tx_pend_reg;
  reg        tx_done_reg;
  wire       tx_tick = (tx_cnt_reg == 16'h0000);

  always @(posedge sys_clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      tx_st_reg   <= TX_IDLE;
      tx_cnt_reg  <= 16'h0000;
      tx_bit_reg  <= 4'h0;
      tx_sh_reg   <= 8'h00;
      txd_reg     <= 8'h00;
      tx_par_reg  <= 1'b0;
      tx_on_reg   <= 1'b0;
      tx_susp_reg <= 1'b0;
      tx_pend_reg <= 1'b0;
      tx_done_reg <= 1'b0;
      tx_line_reg <= 1'b1;
    end
    else
    begin
      tx_done_reg <= 1'b0;
      if (wr_txd)
      begin
        txd_reg     <= wdata_in[7:0];
        tx_pend_reg <= 1'b1;
      end
      if (t_tx_end)
      begin
        tx_on_reg   <= 1'b0;
        tx_susp_reg <= 1'b0;
        tx_st_reg   <= TX_IDLE;
        tx_line_reg <= 1'b1;
      end
      else
      begin
        if (t_tx_go)
        begin
          tx_on_reg   <= 1'b1;
          tx_susp_reg <= 1'b0;
        end
        else if (t_susp)
          tx_susp_reg <= 1'b1;
        if (!tx_tick && tx_st_reg != TX_IDLE)
          tx_cnt_reg <= tx_cnt_reg - 16'h0001;
        else
          tx_cnt_reg <= baud_reg - 16'h0001;
        case (tx_st_reg)
          TX_IDLE:
          begin
            tx_line_reg <= 1'b1;
            if (tx_susp_reg)
            begin
              tx_on_reg   <= 1'b0;
              tx_susp_reg <= 1'b0;
            end
            else if (tx_on_reg && tx_pend_reg && cts_ok && !wr_txd)
            begin
              tx_sh_reg   <= txd_reg;
              tx_par_reg  <= ^txd_reg;
              tx_pend_reg <= 1'b0;
              tx_bit_reg  <= 4'h0;
              tx_line_reg <= 1'b0;
              tx_st_reg   <= TX_START;
            end
          end
          TX_START:
            if (tx_tick)
            begin
              tx_line_reg <= tx_sh_reg[0];
              tx_st_reg   <= TX_DATA;
            end
          TX_DATA:
            if (tx_tick)
            begin
              if (tx_bit_reg == `UF_DATA_LAST)
              begin
                tx_line_reg <= par_en ? tx_par_reg : 1'b1;
                tx_st_reg   <= par_en ? TX_PAR : TX_STOP;
              end
              else
              begin
                tx_sh_reg   <= {1'b0, tx_sh_reg[7:1]};
                tx_line_reg <= tx_sh_reg[1];
                tx_bit_reg  <= tx_bit_reg + 4'h1;
              end
            end
          TX_PAR:
            if (tx_tick)
            begin
              tx_line_reg <= 1'b1;
              tx_st_reg   <= TX_STOP;
            end
          TX_STOP:
            if (tx_tick)
            begin
              tx_st_reg   <= TX_IDLE;
              tx_done_reg <= 1'b1;
            end
          default:
            tx_st_reg <= TX_IDLE;
        endcase
      end
    end
  end

  // receiver
  reg [2:0]  rx_st_reg;
  reg [15:0] rx_cnt_reg;
  reg [3:0]  rx_bit_reg;
  reg [8:0]  rx_sh_reg;
  reg        rx_on_reg;
  reg        rx_stop_reg;
  reg [15:0] to_cnt_reg;
  reg [7:0]  to_bits_reg;
  reg        to_done_reg;
  reg        rx_push_reg;
  reg [7:0]  rx_byte_reg;
  reg        fe_reg;
  reg        pe_reg;
  reg        brk_reg;
  wire       rx_tick = (rx_cnt_reg == 16'h0000);
  wire [3:0] rx_last = par_en ? `UF_PAR_LAST : `UF_DATA_LAST;
  wire [7:0] rx_data = par_en ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
  wire       rx_perr = par_en && (^rx_sh_reg);

  always @(posedge sys_clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rx_st_reg   <= RX_IDLE;
      rx_cnt_reg  <= 16'h0000;
      rx_bit_reg  <= 4'h0;
      rx_sh_reg   <= 9'h000;
      rx_on_reg   <= 1'b0;
      rx_stop_reg <= 1'b0;
      to_cnt_reg  <= 16'h0000;
      to_bits_reg <= 8'h00;
      to_done_reg <= 1'b0;
      rx_push_reg <= 1'b0;
      rx_byte_reg <= 8'h00;
      fe_reg      <= 1'b0;
      pe_reg      <= 1'b0;
      brk_reg     <= 1'b0;
    end
    else
    begin
      rx_push_reg <= 1'b0;
      fe_reg      <= 1'b0;
      pe_reg      <= 1'b0;
      brk_reg     <= 1'b0;
      to_done_reg <= 1'b0;
      if (t_rx_go)
      begin
        rx_on_reg   <= 1'b1;
        rx_stop_reg <= 1'b0;
      end
      else if ((t_rx_end || t_susp) && rx_on_reg && !rx_stop_reg)
      begin
        rx_stop_reg <= 1'b1;
        to_cnt_reg  <= baud_reg - 16'h0001;
        to_bits_reg <= 8'h00;
      end
      else if (rx_stop_reg)
      begin
        // keep receiving for a fixed number of bit times
        if (to_cnt_reg != 16'h0000)
          to_cnt_reg <= to_cnt_reg - 16'h0001;
        else if (to_bits_reg == `UF_RECEIVE_TIMEOUT_EVENT_BITS)
        begin
          rx_on_reg   <= 1'b0;
          rx_stop_reg <= 1'b0;
          to_done_reg <= 1'b1;
        end
        else
        begin
          to_cnt_reg  <= baud_reg - 16'h0001;
          to_bits_reg <= to_bits_reg + 8'h01;
        end
      end
      if (!rx_tick)
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      else
        rx_cnt_reg <= baud_reg - 16'h0001;
      case (rx_st_reg)
        RX_IDLE:
          if (rx_on_reg && !rxd_line)
          begin
            rx_cnt_reg <= {1'b0, baud_reg[15:1]};
            rx_st_reg  <= RX_START;
          end
        RX_START:
          if (rx_tick)
          begin
            rx_bit_reg <= 4'h0;
            rx_st_reg  <= rxd_line ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_tick)
          begin
            rx_sh_reg  <= {rxd_line, rx_sh_reg[8:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == rx_last)
              rx_st_reg <= RX_STOP;
          end
        RX_STOP:
          if (rx_tick)
          begin
            rx_push_reg <= 1'b1;
            rx_byte_reg <= rx_data;
            pe_reg      <= rx_perr;
            fe_reg      <= !rxd_line;
            rx_bit_reg  <= 4'h0;
            rx_st_reg   <= rxd_line ? RX_IDLE : RX_BRK;
          end
        RX_BRK:
          // line still low one bit time after the stop-bit sample is a break
          if (rxd_line)
            rx_st_reg <= RX_IDLE;
          else if (rx_tick && rx_bit_reg == 4'h0)
          begin
            brk_reg    <= 1'b1;
            rx_bit_reg <= 4'h1;
          end
        default:
          rx_st_reg <= RX_IDLE;
      endcase
    end
  end

  // receive FIFO and data register
  wire [7:0] fifo_data;
  wire [2:0] fifo_count;
  wire       fifo_empty;
  reg  [7:0] rxd_reg;
  reg        rxd_full_reg;
  wire       move_in = !rxd_full_reg && !fifo_empty;

  uart_rx_fifo u_fifo (
    .clk_in    (sys_clk_in),
    .rst_n_in  (rst_n_reg),
    .push_in   (rx_push_reg),
    .data_in   (rx_byte_reg),
    .pop_in    (move_in),
    .data_out  (fifo_data),
    .count_out (fifo_count),
    .empty_out (fifo_empty)
  );

  // events, error source and configuration
  reg       ev_rx_reg;
  reg       ev_tx_reg;
  reg       ev_err_reg;
  reg       ev_to_reg;
  reg [2:0] errsrc_reg;
  wire      err_set = fe_reg || pe_reg || brk_reg;
  wire      ev_wr = wr_in && !wdata_in[0];

  always @(posedge sys_clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rxd_reg      <= 8'h00;
      rxd_full_reg <= 1'b0;
      rts_off_reg  <= 1'b1;
      ev_rx_reg    <= 1'b0;
      ev_tx_reg    <= 1'b0;
      ev_err_reg   <= 1'b0;
      ev_to_reg    <= 1'b0;
      errsrc_reg   <= 3'h0;
      enable_reg   <= 1'b0;
      cfg_reg      <= 2'h0;
      baud_reg     <= `UF_BAUD_RST;
      rdata_out    <= 32'h00000000;
    end
    else
    begin
      if (move_in)
      begin
        rxd_reg      <= fifo_data;
        rxd_full_reg <= 1'b1;
      end
      else if (rd_rxd)
        rxd_full_reg <= 1'b0;
      if (!rx_on_reg || rx_stop_reg || fifo_count >= `UF_RTS_FULL)
        rts_off_reg <= 1'b1;
      else if (fifo_count == 3'h0 && !rxd_full_reg)
        rts_off_reg <= 1'b0;
      // a set in the same cycle as a clear wins
      ev_rx_reg  <= move_in  || (ev_rx_reg  && !(ev_wr && addr_in == `UF_OFS_EV_RX));
      ev_tx_reg  <= tx_done_reg || (ev_tx_reg && !(ev_wr && addr_in == `UF_OFS_EV_TX));
      ev_err_reg <= err_set  || (ev_err_reg && !(ev_wr && addr_in == `UF_OFS_EV_ERR));
      ev_to_reg  <= to_done_reg || (ev_to_reg && !(ev_wr && addr_in == `UF_OFS_EV_TO));
      errsrc_reg <= {brk_reg, pe_reg, fe_reg} | (errsrc_reg &
                    ~((wr_in && addr_in == `UF_OFS_ERRSRC) ? wdata_in[2:0] : 3'h0));
      if (wr_in && addr_in == `UF_OFS_ENABLE)
        enable_reg <= wdata_in[0];
      if (wr_in && addr_in == `UF_OFS_CONFIG)
        cfg_reg <= wdata_in[1:0];
      if (wr_in && addr_in == `UF_OFS_BAUD)
        baud_reg <= wdata_in[15:0];
      rdata_out <= 32'h00000000;
      if (rd_in)
      begin
        if (psel_hit)
          rdata_out <= {psel[psel_ofs[3:2]][5], 26'h0000000, psel[psel_ofs[3:2]][4:0]};
        case (addr_in)
          `UF_OFS_EV_RX:  rdata_out <= {31'h00000000, ev_rx_reg};
          `UF_OFS_EV_TX:  rdata_out <= {31'h00000000, ev_tx_reg};
          `UF_OFS_EV_ERR: rdata_out <= {31'h00000000, ev_err_reg};
          `UF_OFS_EV_TO:  rdata_out <= {31'h00000000, ev_to_reg};
          `UF_OFS_ERRSRC: rdata_out <= {29'h00000000, errsrc_reg};
          `UF_OFS_ENABLE: rdata_out <= {31'h00000000, enable_reg};
          `UF_OFS_RXD:    rdata_out <= {24'h000000, rxd_reg};
          `UF_OFS_BAUD:   rdata_out <= {16'h0000, baud_reg};
          `UF_OFS_CONFIG: rdata_out <= {30'h00000000, cfg_reg};
          default:        ;
        endcase
      end
    end
  end

endmodule // uart_flow_control_core

/* uart_flow_control_core_assertions.sv */
`include "uart_map.vh"

module uart_flow_control_core_checker (
  input wire                   sys_clk_in,
  input wire                   arst_n_in,
  input wire [`UF_ADDR_W-1:0]  addr_in,
  input wire [`UF_DATA_W-1:0]  wdata_in,
  input wire                   wr_in,
  input wire                   rd_in,
  input wire [`UF_DATA_W-1:0]  rdata_out,
  input wire [`UF_PIN_NUM-1:0] pin_in,
  input wire [`UF_PIN_NUM-1:0] pin_out,
  input wire [`UF_PIN_NUM-1:0] pin_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]  tx_sel_reg;
  logic [5:0]  rts_sel_reg;
  logic        en_reg;
  logic        fc_reg;
  logic        tx_go_reg;
  logic [3:0]  kick_reg;
  logic [31:0] drv_mask;
  wire         task_wr = wr_in && wdata_in[0];
  wire         tx = pin_out[tx_sel_reg[4:0]];
  wire         rts = pin_out[rts_sel_reg[4:0]];
  wire         tx_on = en_reg && !tx_sel_reg[5];
  wire         fc_on = en_reg && fc_reg && !rts_sel_reg[5];

  always_comb
  begin
    drv_mask = '0;
    if (tx_on)
      drv_mask[tx_sel_reg[4:0]] = 1'b1;
    if (en_reg && !rts_sel_reg[5])
      drv_mask[rts_sel_reg[4:0]] = 1'b1;
  end

  // mirror of what software configured; kick_reg opens a short window after an rts release cause
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      tx_sel_reg <= 6'h20;
      rts_sel_reg <= 6'h20;
      en_reg <= 1'b0;
      fc_reg <= 1'b0;
      tx_go_reg <= 1'b0;
      kick_reg <= 4'h0;
    end
    else
    begin
      if (wr_in && addr_in == `UF_OFS_PSEL)
        rts_sel_reg <= {wdata_in[31], wdata_in[4:0]};
      if (wr_in && addr_in == `UF_OFS_PSEL + 12'h004)
        tx_sel_reg <= {wdata_in[31], wdata_in[4:0]};
      if (wr_in && addr_in == `UF_OFS_ENABLE)
        en_reg <= wdata_in[0];
      if (wr_in && addr_in == `UF_OFS_CONFIG)
        fc_reg <= wdata_in[`UF_CFG_HWFC];
      if (task_wr && addr_in == `UF_OFS_TX_GO)
        tx_go_reg <= 1'b1;
      if ((rd_in && addr_in == `UF_OFS_RXD) || (wr_in && (addr_in == `UF_OFS_RX_GO
          || addr_in == `UF_OFS_CONFIG || addr_in == `UF_OFS_ENABLE)))
        kick_reg <= 4'h8;
      else if (kick_reg != 4'h0)
        kick_reg <= kick_reg - 4'h1;
    end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == '0)
    else $error("read data outside answer cycle");
  rxd_width_a: assert property (rd_in && addr_in == `UF_OFS_RXD |=> rdata_out[31:8] == '0)
    else $error("receive data wider than a byte");
  pins_free_a: assert property ((pin_oe_out & ~(drv_mask | $past(drv_mask))) == '0)
    else $error("unselected pin driven");
  tx_start_a: assert property (tx_on && $fell(tx) |-> tx_go_reg)
    else $error("transmit began without begin task");
  tx_abort_a: assert property (task_wr && addr_in == `UF_OFS_TX_END && tx_on |=> tx [*4])
    else $error("transmit line not idle after end task");
  rts_noflow_a: assert property ((en_reg && !rts_sel_reg[5] && !fc_reg) [*2] |-> !rts)
    else $error("rts inactive without flow control");
  rts_stop_a: assert property (task_wr && fc_on && (addr_in == `UF_OFS_RX_END
      || addr_in == `UF_OFS_SUSPEND) |-> ##[1:4] rts)
    else $error("rts still active after receive stop");
  rts_return_a: assert property ($fell(rts) && fc_on |-> kick_reg != 4'h0)
    else $error("rts returned without cause");
endmodule // uart_flow_control_core_checker

bind uart_flow_control_core uart_flow_control_core_checker u_chk (.sys_clk_in(sys_clk_in),
  .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out));

/* uart_map.vh */
`ifndef UART_MAP_VH
`define UART_MAP_VH

`define UF_ADDR_W       12
`define UF_DATA_W       32
`define UF_OFS_RX_GO    12'h000
`define UF_OFS_RX_END   12'h004
`define UF_OFS_TX_GO    12'h008
`define UF_OFS_TX_END   12'h00C
`define UF_OFS_SUSPEND  12'h01C
`define UF_OFS_EV_RX    12'h108
`define UF_OFS_EV_TX    12'h11C
`define UF_OFS_EV_ERR   12'h124
`define UF_OFS_EV_TO    12'h144
`define UF_OFS_ERRSRC   12'h480
`define UF_OFS_ENABLE   12'h500
`define UF_OFS_PSEL     12'h508
`define UF_OFS_RXD      12'h518
`define UF_OFS_TXD      12'h51C
`define UF_OFS_BAUD     12'h524
`define UF_OFS_CONFIG   12'h56C
`define UF_PSEL_SPAN    12'h010
`define UF_PSEL_RTS     0
`define UF_PSEL_TXD     1
`define UF_PSEL_CTS     2
`define UF_PSEL_RXD     3
`define UF_PSEL_NUM     4
`define UF_PSEL_DISC    31
`define UF_PSEL_RST     6'h20
`define UF_PIN_NUM      32
`define UF_CFG_HWFC     0
`define UF_CFG_PAR      1
`define UF_ERR_FRAME    0
`define UF_ERR_PARITY   1
`define UF_ERR_BREAK    2
`define UF_BAUD_RST     16'h01B2
`define UF_DATA_LAST    4'h7
`define UF_PAR_LAST     4'h8
`define UF_FIFO_DEPTH   6
`define UF_FIFO_LAST    3'h5
`define UF_RTS_FULL     3'h2
`define UF_RECEIVE_TIMEOUT_EVENT_BITS    8'h37

`endif

/* uart_peer.sv */
module uart_peer #(
  parameter int BAUD = 8
) (
  input  wire logic clk_in,
  input  wire logic line_in,
  input  wire logic rts_n_in,
  output logic      line_out,
  output logic      cts_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       par_on = 1'b0;
  logic       par_bad = 1'b0;
  logic [9:0] got_q[$];
  logic [9:0] f;

  initial
  begin
    line_out = 1'b1;
    cts_n_out = 1'b0;
  end

  // capture: f[7:0] data lsb first, f[8] parity, f[9] stop level
  always
  begin
    @(negedge line_in);
    repeat (BAUD / 2) @(posedge clk_in);
    f = 10'h000;
    for (int i = 0; i < 10; i++)
      if (i != 8 || par_on)
      begin
        repeat (BAUD) @(posedge clk_in);
        f[i] = line_in;
      end
    got_q.push_back(f);
  end

  task automatic send(input logic [7:0] b, input logic stop_v, input logic obey);
    logic [10:0] fr;
    fr = {stop_v, ^b ^ par_bad, b, 1'b0};
    while (obey && rts_n_in)
      @(posedge clk_in);
    @(posedge clk_in);
    for (int i = 0; i < 11; i++)
      if (i != 9 || par_on)
      begin
        line_out <= fr[i];
        repeat (BAUD) @(posedge clk_in);
      end
    line_out <= 1'b1;
  endtask

  // clear-to-send changes just after a clock edge, like every other input
  task automatic set_cts(input logic v);
    @(posedge clk_in);
    cts_n_out <= v;
  endtask

  task automatic brk(input int n);
    @(posedge clk_in);
    line_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    line_out <= 1'b1;
  endtask
endmodule // uart_peer

/* uart_rx_fifo.v */
`include "uart_map.vh"

module uart_rx_fifo (
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire       push_in,
  input  wire [7:0] data_in,
  input  wire       pop_in,
  output wire [7:0] data_out,
  output reg  [2:0] count_out,
  output wire       empty_out
);

  reg [7:0] mem [0:`UF_FIFO_DEPTH-1];
  reg [2:0] wr_ptr_reg;
  reg [2:0] rd_ptr_reg;
  wire      full = (count_out == `UF_FIFO_LAST + 3'h1);
  wire      do_pop = pop_in && !empty_out;
  // when full and not drained, the newest entry is overwritten
  wire      over = push_in && full && !do_pop;
  wire [2:0] wr_last = (wr_ptr_reg == 3'h0) ? `UF_FIFO_LAST : wr_ptr_reg - 3'h1;

  assign empty_out = (count_out == 3'h0);
  assign data_out  = mem[rd_ptr_reg];

  always @(posedge clk_in)
  begin
    if (push_in)
      mem[over ? wr_last : wr_ptr_reg] <= data_in;
  end

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_reg <= 3'h0;
      rd_ptr_reg <= 3'h0;
      count_out  <= 3'h0;
    end
    else
    begin
      if (push_in && !over)
        wr_ptr_reg <= (wr_ptr_reg == `UF_FIFO_LAST) ? 3'h0 : wr_ptr_reg + 3'h1;
      if (do_pop)
        rd_ptr_reg <= (rd_ptr_reg == `UF_FIFO_LAST) ? 3'h0 : rd_ptr_reg + 3'h1;
      if (push_in && !over && !do_pop)
        count_out <= count_out + 3'h1;
      else if (do_pop && !(push_in && !over))
        count_out <= count_out - 3'h1;
    end
  end

endmodule // uart_rx_fifo
